// ===== logic/cce_pkg.sv
// Overview of operation
// - a call pushes the current program counter plus one onto the stack
// - after the push the program counter takes the call target unconditionally
// - a call takes two instruction cycles to complete
// - byte zero writes 00 to the addressed byte, flags untouched
// - bit zero clears only the selected bit, other bits and flags kept
// - single-step clear resets watchdog counter and clears both flags
// - the two half clears work only as an alternating pair
// - repeated first halves alone change neither counter nor flags
// - repeated second halves alone change neither counter nor flags
// - bitwise invert writes the ones complement back to the same byte
// - via the half clears, flags clear only after both halves ran one after the other
// - power-down entry sets power-down flag and clears time-out flag
package cce_pkg;

  // ==========================================================
  // widths
  localparam int PC_W   = 11;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_W  = 3;

  // ==========================================================
  // values and timing
  localparam logic [DATA_W-1:0] BYTE_ZERO_VALUE = 8'h00;
  localparam int                RET_STEP        = 1;
  localparam int                CALL_CYCLES     = 2;
  localparam logic              FLAG_RST        = 1'b0;

  // ==========================================================
  // operations and states
  typedef enum logic [2:0] {
    OP_NOP,
    OP_CALL,
    OP_BYTE_ZERO,
    OP_BIT_ZERO,
    OP_INVERT,
    OP_WDT_SINGLE,
    OP_WDT_FIRST,
    OP_WDT_SECOND
  } cce_op_e;

  typedef enum logic [1:0] {
    HALF_NONE,
    HALF_FIRST,
    HALF_SECOND
  } cce_half_e;

endpackage

// ===== logic/cce_wdt_if.sv
`timescale 1ns/1ps
interface cce_wdt_if;
  logic              firstHalf;
  logic              secondHalf;
  logic              clearReq;
  cce_pkg::cce_half_e pendState;

  modport exec (
    output firstHalf,
    output secondHalf,
    input  clearReq,
    input  pendState
  );

  modport pair (
    input  firstHalf,
    input  secondHalf,
    output clearReq,
    output pendState
  );
endinterface

// ===== logic/cce_data_mem.sv
`timescale 1ns/1ps
module cce_data_mem #(
  parameter int DATA_W = cce_pkg::DATA_W,
  parameter int ADDR_W = cce_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              clkEn,
  // write port
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  // read ports
  input  wire logic [ADDR_W-1:0] rdAddrA,
  output logic      [DATA_W-1:0] rdDataA,
  input  wire logic [ADDR_W-1:0] rdAddrB,
  output logic      [DATA_W-1:0] rdDataB
);
  logic [DATA_W-1:0] memArray [2**ADDR_W];

  // ==========================================================
  // storage, read during write returns old data
  always_ff @(posedge clk) begin
    if (clkEn && wrEn) begin
      memArray[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdDataA <= '0;
      rdDataB <= '0;
    end else if (clkEn) begin
      rdDataA <= memArray[rdAddrA];
      rdDataB <= memArray[rdAddrB];
    end
  end
endmodule

// ===== logic/cce_wdt_pair.sv
`timescale 1ns/1ps
module cce_wdt_pair (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic clkEn,
  // half-clear requests
  cce_wdt_if.pair   wdt
);
  cce_pkg::cce_half_e pendReg;
  cce_pkg::cce_half_e pendNext;

  // ==========================================================
  // pair detection
  assign wdt.clearReq = (wdt.firstHalf && pendReg == cce_pkg::HALF_SECOND) ||
                        (wdt.secondHalf && pendReg == cce_pkg::HALF_FIRST);
  assign wdt.pendState = pendReg;

  always_comb begin
    pendNext = pendReg;
    case (pendReg)
      cce_pkg::HALF_NONE,
      cce_pkg::HALF_FIRST,
      cce_pkg::HALF_SECOND: begin
        // a completed pair is consumed, a new pair is needed next time
        if (wdt.clearReq) begin
          pendNext = cce_pkg::HALF_NONE;
        end else if (wdt.firstHalf) begin
          pendNext = cce_pkg::HALF_FIRST;
        end else if (wdt.secondHalf) begin
          pendNext = cce_pkg::HALF_SECOND;
        end
      end
      default: pendNext = cce_pkg::HALF_NONE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pendReg <= cce_pkg::HALF_NONE;
    end else if (clkEn) begin
      pendReg <= pendNext;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_repeat_first;
    wdt.firstHalf && pendReg == cce_pkg::HALF_FIRST |-> !wdt.clearReq;
  endproperty
  a_repeat_first: assert property (p_repeat_first)
    else $error("repeated first half cleared");

  property p_repeat_second;
    wdt.secondHalf && pendReg == cce_pkg::HALF_SECOND |-> !wdt.clearReq;
  endproperty
  a_repeat_second: assert property (p_repeat_second)
    else $error("repeated second half cleared");

  property p_pair_consumed;
    wdt.clearReq && clkEn |=> pendReg == cce_pkg::HALF_NONE;
  endproperty
  a_pair_consumed: assert property (p_pair_consumed)
    else $error("pair record not emptied");
endmodule

// ===== logic/cce_exec.sv
`timescale 1ns/1ps
module cce_exec #(
  parameter int PC_W   = cce_pkg::PC_W,
  parameter int DATA_W = cce_pkg::DATA_W,
  parameter int ADDR_W = cce_pkg::ADDR_W,
  parameter int BIT_W  = cce_pkg::BIT_W
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              clkEn,
  // instruction issue
  input  wire logic              instValid,
  input  cce_pkg::cce_op_e       instOp,
  input  wire logic [ADDR_W-1:0] instAddr,
  input  wire logic [BIT_W-1:0]  instBit,
  input  wire logic [PC_W-1:0]   instTarget,
  input  wire logic [PC_W-1:0]   curPc,
  output logic                   instReady,
  output logic                   instDone,
  // program counter and stack
  output logic                   stackPush,
  output logic      [PC_W-1:0]   stackData,
  output logic                   pcLoad,
  output logic      [PC_W-1:0]   pcValue,
  // watchdog and status flags
  input  wire logic              wdtTimeout,
  input  wire logic              haltEnter,
  output logic                   wdtClear,
  output logic                   timeoutFlag,
  output logic                   powerDownFlag,
  // data memory load and observe
  input  wire logic              loadValid,
  input  wire logic [ADDR_W-1:0] loadAddr,
  input  wire logic [DATA_W-1:0] loadData,
  input  wire logic [ADDR_W-1:0] obsAddr,
  output logic      [DATA_W-1:0] obsData
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RMW,
    ST_CALL_JUMP
  } cce_state_e;

  // ==========================================================
  // helpers
  function automatic logic [DATA_W-1:0] bitMask(input logic [BIT_W-1:0] pos);
    logic [DATA_W-1:0] m;
    m = '0;
    m[pos] = 1'b1;
    return m;
  endfunction

  function automatic logic [PC_W-1:0] retAddr(input logic [PC_W-1:0] pc);
    return pc + PC_W'(cce_pkg::RET_STEP);
  endfunction

  cce_state_e        stateReg;
  cce_state_e        stateNext;
  cce_pkg::cce_op_e  holdOpReg;
  logic [ADDR_W-1:0] holdAddrReg;
  logic [BIT_W-1:0]  holdBitReg;
  logic [PC_W-1:0]   holdTargetReg;
  logic              accept;
  logic              clearFlags;
  logic              memWrEn;
  logic [ADDR_W-1:0] memWrAddr;
  logic [DATA_W-1:0] memWrData;
  logic [DATA_W-1:0] memRdA;
  logic [DATA_W-1:0] rmwData;
  cce_wdt_if         wdtBus ();

  // ==========================================================
  // issue
  assign accept = instValid && instReady && stateReg == ST_IDLE;

  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      ST_IDLE: begin
        if (accept && instOp == cce_pkg::OP_CALL) begin
          stateNext = ST_CALL_JUMP;
        end else if (accept && (instOp == cce_pkg::OP_BIT_ZERO ||
                                instOp == cce_pkg::OP_INVERT)) begin
          stateNext = ST_RMW;
        end
      end
      ST_RMW:       stateNext = ST_IDLE;
      ST_CALL_JUMP: stateNext = ST_IDLE;
      default:      stateNext = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stateReg  <= ST_IDLE;
      instReady <= 1'b0;
    end else if (clkEn) begin
      stateReg  <= stateNext;
      instReady <= stateNext == ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      holdOpReg     <= cce_pkg::OP_NOP;
      holdAddrReg   <= '0;
      holdBitReg    <= '0;
      holdTargetReg <= '0;
    end else if (clkEn && accept) begin
      holdOpReg     <= instOp;
      holdAddrReg   <= instAddr;
      holdBitReg    <= instBit;
      holdTargetReg <= instTarget;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      instDone <= 1'b0;
    end else if (clkEn) begin
      instDone <= (accept && stateNext == ST_IDLE) || stateReg != ST_IDLE;
    end
  end

  // ==========================================================
  // call: push now, redirect one cycle later
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stackPush <= 1'b0;
      stackData <= '0;
    end else if (clkEn) begin
      stackPush <= accept && instOp == cce_pkg::OP_CALL;
      if (accept && instOp == cce_pkg::OP_CALL) begin
        stackData <= retAddr(curPc);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pcLoad  <= 1'b0;
      pcValue <= '0;
    end else if (clkEn) begin
      pcLoad <= stateReg == ST_CALL_JUMP;
      if (stateReg == ST_CALL_JUMP) begin
        pcValue <= holdTargetReg;
      end
    end
  end

  // ==========================================================
  // data memory, issue stalls during rmw so no stale read
  always_comb begin
    if (holdOpReg == cce_pkg::OP_INVERT) begin
      rmwData = ~memRdA;
    end else begin
      rmwData = memRdA & ~bitMask(holdBitReg);
    end
  end

  always_comb begin
    memWrEn   = loadValid;
    memWrAddr = loadAddr;
    memWrData = loadData;
    if (stateReg == ST_RMW) begin
      memWrEn   = 1'b1;
      memWrAddr = holdAddrReg;
      memWrData = rmwData;
    end else if (accept && instOp == cce_pkg::OP_BYTE_ZERO) begin
      memWrEn   = 1'b1;
      memWrAddr = instAddr;
      memWrData = cce_pkg::BYTE_ZERO_VALUE;
    end
  end

  cce_data_mem #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
  ) u_mem (
    .clk     (clk),
    .rst_b   (rst_b),
    .clkEn   (clkEn),
    .wrEn    (memWrEn),
    .wrAddr  (memWrAddr),
    .wrData  (memWrData),
    .rdAddrA (instAddr),
    .rdDataA (memRdA),
    .rdAddrB (obsAddr),
    .rdDataB (obsData)
  );

  // ==========================================================
  // watchdog clears and flags
  assign wdtBus.firstHalf  = accept && instOp == cce_pkg::OP_WDT_FIRST;
  assign wdtBus.secondHalf = accept && instOp == cce_pkg::OP_WDT_SECOND;

  cce_wdt_pair u_pair (
    .clk   (clk),
    .rst_b (rst_b),
    .clkEn (clkEn),
    .wdt   (wdtBus.pair)
  );

  assign clearFlags = (accept && instOp == cce_pkg::OP_WDT_SINGLE) ||
                      wdtBus.clearReq;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wdtClear <= 1'b0;
    end else if (clkEn) begin
      wdtClear <= clearFlags || haltEnter;
    end
  end

  // a time-out in the clearing cycle still sets the flag
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timeoutFlag <= cce_pkg::FLAG_RST;
    end else if (clkEn) begin
      if (wdtTimeout) begin
        timeoutFlag <= 1'b1;
      end else if (haltEnter || clearFlags) begin
        timeoutFlag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      powerDownFlag <= cce_pkg::FLAG_RST;
    end else if (clkEn) begin
      if (haltEnter) begin
        powerDownFlag <= 1'b1;
      end else if (clearFlags) begin
        powerDownFlag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_call_push;
    accept && clkEn && instOp == cce_pkg::OP_CALL |=>
      stackPush && stackData == $past(curPc) + PC_W'(cce_pkg::RET_STEP);
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call push wrong");

  property p_call_jump;
    (accept && clkEn && instOp == cce_pkg::OP_CALL) ##1 clkEn |=>
      pcLoad && !stackPush && pcValue == $past(instTarget, 2);
  endproperty
  a_call_jump: assert property (p_call_jump)
    else $error("call target not loaded");

  property p_call_two;
    accept && clkEn && instOp == cce_pkg::OP_CALL |=> !instReady && !pcLoad;
  endproperty
  a_call_two: assert property (p_call_two)
    else $error("call not two cycles");

  property p_byte_zero;
    accept && instOp == cce_pkg::OP_BYTE_ZERO |->
      memWrEn && memWrAddr == instAddr && memWrData == cce_pkg::BYTE_ZERO_VALUE;
  endproperty
  a_byte_zero: assert property (p_byte_zero)
    else $error("byte zero wrong");

  property p_bit_zero;
    accept && clkEn && instOp == cce_pkg::OP_BIT_ZERO |=>
      memWrEn && memWrAddr == $past(instAddr) &&
      (memWrData | bitMask($past(instBit))) == (memRdA | bitMask($past(instBit))) &&
      (memWrData & bitMask($past(instBit))) == '0;
  endproperty
  a_bit_zero: assert property (p_bit_zero)
    else $error("bit zero wrong");

  property p_invert;
    accept && clkEn && instOp == cce_pkg::OP_INVERT |=>
      memWrEn && memWrAddr == $past(instAddr) && (memWrData ^ memRdA) == '1;
  endproperty
  a_invert: assert property (p_invert)
    else $error("invert wrong");

  property p_single_clear;
    accept && clkEn && instOp == cce_pkg::OP_WDT_SINGLE && !wdtTimeout && !haltEnter |=>
      wdtClear && !timeoutFlag && !powerDownFlag;
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("single clear failed");

  property p_flags_hold;
    clkEn && !clearFlags && !haltEnter && !wdtTimeout |=>
      $stable(timeoutFlag) && $stable(powerDownFlag) && !wdtClear;
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("flags changed without clear");

  property p_halt;
    clkEn && haltEnter && !wdtTimeout |=> powerDownFlag && !timeoutFlag;
  endproperty
  a_halt: assert property (p_halt)
    else $error("power-down entry flags wrong");

  property p_half_record;
    clkEn && wdtBus.firstHalf && !wdtBus.clearReq |=> wdtBus.pendState == cce_pkg::HALF_FIRST;
  endproperty
  a_half_record: assert property (p_half_record)
    else $error("first half not recorded");

  c_call:   cover property (accept && instOp == cce_pkg::OP_CALL ##2 pcLoad);
  c_pair:   cover property (wdtBus.firstHalf ##[1:8] wdtBus.secondHalf && wdtClear == 1'b0);
  c_invert: cover property (accept && instOp == cce_pkg::OP_INVERT ##1 memWrEn);
  c_race:   cover property (clearFlags && wdtTimeout);
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // signals
  logic                              clk;
  logic                              rst_b;
  logic                              clkEn;
  logic                              instValid;
  cce_pkg::cce_op_e                  instOp;
  logic [cce_pkg::ADDR_W-1:0]        instAddr;
  logic [cce_pkg::BIT_W-1:0]         instBit;
  logic [cce_pkg::PC_W-1:0]          instTarget;
  logic [cce_pkg::PC_W-1:0]          curPc;
  logic                              instReady;
  logic                              instDone;
  logic                              stackPush;
  logic [cce_pkg::PC_W-1:0]          stackData;
  logic                              pcLoad;
  logic [cce_pkg::PC_W-1:0]          pcValue;
  logic                              wdtTimeout;
  logic                              haltEnter;
  logic                              wdtClear;
  logic                              timeoutFlag;
  logic                              powerDownFlag;
  logic                              loadValid;
  logic [cce_pkg::ADDR_W-1:0]        loadAddr;
  logic [cce_pkg::DATA_W-1:0]        loadData;
  logic [cce_pkg::ADDR_W-1:0]        obsAddr;
  logic [cce_pkg::DATA_W-1:0]        obsData;
  int                                errors;
  int                                check_count;
  int                                cycles;

  cce_exec u_cce_exec (
    .clk(clk), .rst_b(rst_b), .clkEn(clkEn),
    .instValid(instValid), .instOp(instOp), .instAddr(instAddr), .instBit(instBit),
    .instTarget(instTarget), .curPc(curPc), .instReady(instReady), .instDone(instDone),
    .stackPush(stackPush), .stackData(stackData), .pcLoad(pcLoad), .pcValue(pcValue),
    .wdtTimeout(wdtTimeout), .haltEnter(haltEnter), .wdtClear(wdtClear),
    .timeoutFlag(timeoutFlag), .powerDownFlag(powerDownFlag),
    .loadValid(loadValid), .loadAddr(loadAddr), .loadData(loadData),
    .obsAddr(obsAddr), .obsData(obsData)
  );

  // ==========================================================
  // clock and hang guard
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // whole run is well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("ERROR %0t run timed out", $time);
      wrap_up();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // returns at the negedge after the take edge
  task automatic issue(input cce_pkg::cce_op_e op, input logic [6:0] addr,
                       input logic [2:0] bitSel, input logic [10:0] tgt, input logic [10:0] pc);
    int n;
    n = 0;
    @(negedge clk);
    while (instReady !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    instOp = op;
    instAddr = addr;
    instBit = bitSel;
    instTarget = tgt;
    curPc = pc;
    instValid = 1'b1;
    @(negedge clk);
    instValid = 1'b0;
    instOp = cce_pkg::OP_NOP;
  endtask

  task automatic poke(input logic [6:0] addr, input logic [7:0] data);
    @(negedge clk);
    loadAddr = addr;
    loadData = data;
    loadValid = 1'b1;
    @(negedge clk);
    loadValid = 1'b0;
  endtask

  task automatic peek(input logic [6:0] addr, input logic [7:0] exp, input string msg);
    @(negedge clk);
    obsAddr = addr;
    @(negedge clk);
    chk(obsData, exp, msg);
  endtask

  // power-down entry then a time-out leaves both flags set
  task automatic set_flags();
    @(negedge clk);
    haltEnter = 1'b1;
    @(negedge clk);
    haltEnter = 1'b0;
    chk(wdtClear, 1'b1, "halt clear");
    chk(powerDownFlag, 1'b1, "halt pdf");
    chk(timeoutFlag, 1'b0, "halt to");
    wdtTimeout = 1'b1;
    @(negedge clk);
    wdtTimeout = 1'b0;
    chk(timeoutFlag, 1'b1, "to set");
  endtask

  task automatic wdt_op(input cce_pkg::cce_op_e op, input logic fire);
    issue(op, 7'h00, 3'h0, 11'h000, 11'h000);
    chk(wdtClear, fire, "wdt clear");
    chk(timeoutFlag, !fire, "to flag");
    chk(powerDownFlag, !fire, "pdf flag");
  endtask

  // ==========================================================
  // scenarios
  task automatic test_reset();
    chk(instReady, 1'b0, "reset ready");
    chk(timeoutFlag | powerDownFlag | instDone | wdtClear, 1'b0, "reset outputs");
    $display("test reset done");
  endtask

  task automatic test_call();
    issue(cce_pkg::OP_CALL, 7'h00, 3'h0, 11'h555, 11'h3FF);
    chk(stackPush, 1'b1, "push");
    chk(stackData, 11'h400, "return address");
    chk(pcLoad, 1'b0, "load before push");
    chk(instReady, 1'b0, "call stall");
    repeat (cce_pkg::CALL_CYCLES - 1) @(negedge clk);
    chk(pcLoad, 1'b1, "pc load");
    chk(pcValue, 11'h555, "pc target");
    chk(instDone, 1'b1, "call done");
    chk(stackPush, 1'b0, "single push");
    $display("test call done");
  endtask

  task automatic test_memory();
    set_flags();
    poke(7'h7F, 8'h3C);
    poke(7'h7E, 8'h81);
    issue(cce_pkg::OP_BYTE_ZERO, 7'h7F, 3'h0, 11'h000, 11'h000);
    chk(instDone, 1'b1, "byte done");
    peek(7'h7F, 8'h00, "byte zero");
    peek(7'h7E, 8'h81, "neighbour kept");
    for (int i = 0; i < 8; i++) begin
      poke(7'h10, 8'hFF);
      issue(cce_pkg::OP_BIT_ZERO, 7'h10, 3'(i), 11'h000, 11'h000);
      chk(instDone, 1'b0, "bit early");
      @(negedge clk);
      chk(instDone, 1'b1, "bit done");
      peek(7'h10, ~(8'h01 << i), "bit zero");
    end
    poke(7'h20, 8'hA5);
    issue(cce_pkg::OP_INVERT, 7'h20, 3'h0, 11'h000, 11'h000);
    peek(7'h20, 8'h5A, "invert");
    issue(cce_pkg::OP_INVERT, 7'h20, 3'h0, 11'h000, 11'h000);
    peek(7'h20, 8'hA5, "invert back");
    chk({timeoutFlag, powerDownFlag}, 2'b11, "flags kept");
    $display("test memory done");
  endtask

  task automatic test_wdt();
    set_flags();
    wdt_op(cce_pkg::OP_WDT_SINGLE, 1'b1);
    set_flags();
    wdt_op(cce_pkg::OP_WDT_FIRST, 1'b0);
    wdt_op(cce_pkg::OP_WDT_FIRST, 1'b0);
    wdt_op(cce_pkg::OP_WDT_SECOND, 1'b1);
    set_flags();
    wdt_op(cce_pkg::OP_WDT_SECOND, 1'b0);
    wdt_op(cce_pkg::OP_WDT_SECOND, 1'b0);
    wdt_op(cce_pkg::OP_WDT_FIRST, 1'b1);
    set_flags();
    wdt_op(cce_pkg::OP_WDT_FIRST, 1'b0);
    wdt_op(cce_pkg::OP_NOP, 1'b0);
    wdt_op(cce_pkg::OP_WDT_SECOND, 1'b1);
    $display("test wdt done");
  endtask

  // a time-out or power-down entry in the clearing cycle wins over the clear
  task automatic test_race();
    set_flags();
    @(negedge clk);
    instOp = cce_pkg::OP_WDT_SINGLE;
    instValid = 1'b1;
    wdtTimeout = 1'b1;
    @(negedge clk);
    instValid = 1'b0;
    wdtTimeout = 1'b0;
    instOp = cce_pkg::OP_NOP;
    chk({timeoutFlag, powerDownFlag, wdtClear}, 3'b101, "timeout beats clear");
    @(negedge clk);
    instOp = cce_pkg::OP_WDT_SINGLE;
    instValid = 1'b1;
    haltEnter = 1'b1;
    @(negedge clk);
    instValid = 1'b0;
    haltEnter = 1'b0;
    instOp = cce_pkg::OP_NOP;
    chk({timeoutFlag, powerDownFlag, wdtClear}, 3'b011, "halt beats clear");
    $display("test race done");
  endtask

  // clkEn low must hold off the take entirely
  task automatic test_freeze();
    set_flags();
    @(negedge clk);
    clkEn = 1'b0;
    instOp = cce_pkg::OP_WDT_SINGLE;
    instValid = 1'b1;
    repeat (3) @(negedge clk);
    chk(wdtClear | instDone, 1'b0, "frozen take");
    chk({timeoutFlag, powerDownFlag}, 2'b11, "frozen flags");
    instValid = 1'b0;
    clkEn = 1'b1;
    instOp = cce_pkg::OP_NOP;
    @(negedge clk);
    chk(wdtClear, 1'b0, "no late clear");
    $display("test freeze done");
  endtask

  task automatic test_rereset();
    wdt_op(cce_pkg::OP_WDT_FIRST, 1'b0);
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    chk({timeoutFlag, powerDownFlag, instReady}, 3'b000, "mid reset");
    rst_b = 1'b1;
    set_flags();
    wdt_op(cce_pkg::OP_WDT_SECOND, 1'b0);
    $display("test rereset done");
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    errors = 0;
    check_count = 0;
    cycles = 0;
    rst_b = 1'b0;
    clkEn = 1'b1;
    instValid = 1'b0;
    instOp = cce_pkg::OP_NOP;
    instAddr = '0;
    instBit = '0;
    instTarget = '0;
    curPc = '0;
    wdtTimeout = 1'b0;
    haltEnter = 1'b0;
    loadValid = 1'b0;
    loadAddr = '0;
    loadData = '0;
    obsAddr = '0;
    repeat (5) @(negedge clk);
    test_reset();
    rst_b = 1'b1;
    test_call();
    test_memory();
    test_wdt();
    test_race();
    test_freeze();
    test_rereset();
    wrap_up();
  end
endmodule
